//--- logic/hs_port_owner_power_line_status.sv
/*
 * Port owner, port power, indicator select and line-level status bits of one
 * root hub port, with configured_flag and a read-only structural_params word,
 * all behind a classic Wishbone slave.
 * Assumes line pins are asynchronous, overcurrent is asynchronous, and the
 * connect and enable status comes from port logic on ref_clk.
 */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module hs_port_owner_power_line_status #(
  parameter logic IND_CAPABLE = 1'b1,
  parameter logic PWR_CAPABLE = 1'b1,
  parameter int SETTLE_CYCLES = port_owner_pkg::PWR_SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dp_line,
  input wire logic dm_line,
  input wire logic overcurrent,
  input wire logic port_connected,
  input wire logic port_enabled,
  output logic port_power_on,
  output logic owner_is_companion,
  output logic route_to_companion,
  output logic [1:0] indicator_select,
  output logic power_settled
);
  import port_owner_pkg::*;

  // ************************************************************
  // bus decode
  // ************************************************************
  logic ack_q;
  logic [31:0] rdat_q;
  logic wr_stb;
  logic configured_flag_q;
  logic cfg_prev_q;
  logic owner_q;
  logic power_q;
  logic [1:0] ind_q;
  logic [2:0] dp_sync_q;
  logic [2:0] dm_sync_q;
  logic [2:0] oc_sync_q;
  logic dp_q;
  logic dm_q;
  logic oc_q;
  logic [31:0] settle_cnt_q;
  logic port_wr;
  logic status_rd;
  logic line_ok;
  logic [1:0] line_now;
  logic [1:0] ind_wdata;
  logic owner_wdata;
  logic power_wdata;

  // write strobe seen once per classic cycle, at the ack edge; a request
  // dropped before ack therefore leaves every register untouched
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base);
    hit = (adr == base);
  endfunction : hit

  // ack one cycle after request; dropped the cycle after it was given
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ************************************************************
  // pin synchronisers: third and second stage must agree
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_sync_q <= 3'h0;
      dm_sync_q <= 3'h0;
      oc_sync_q <= 3'h0;
      dp_q <= 1'b0;
      dm_q <= 1'b0;
      oc_q <= 1'b0;
    end else begin
      dp_sync_q <= {dp_sync_q[1:0], dp_line};
      dm_sync_q <= {dm_sync_q[1:0], dm_line};
      oc_sync_q <= {oc_sync_q[1:0], overcurrent};
      if (dp_sync_q[1] == dp_sync_q[2]) begin
        dp_q <= dp_sync_q[2];
      end
      if (dm_sync_q[1] == dm_sync_q[2]) begin
        dm_q <= dm_sync_q[2];
      end
      if (oc_sync_q[1] == oc_sync_q[2]) begin
        oc_q <= oc_sync_q[2];
      end
    end
  end

  // ************************************************************
  // configured flag
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      configured_flag_q <= RST_CFG_FLAG;
      cfg_prev_q <= RST_CFG_FLAG;
    end else begin
      cfg_prev_q <= configured_flag_q;
      if (wr_stb && hit(wb_adr_i, ADDR_CONFIG_DONE) && wb_sel_i[0]) begin
        configured_flag_q <= wb_dat_i[POS_CFG_FLAG];
      end
    end
  end

  assign route_to_companion = !configured_flag_q;

  // ************************************************************
  // port owner
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      owner_q <= RST_OWNER;
    end else if (!configured_flag_q) begin
      owner_q <= 1'b1;
    end else if (!cfg_prev_q) begin
      owner_q <= 1'b0;
    end else if (wr_stb && hit(wb_adr_i, ADDR_PORT_STATUS) && wb_sel_i[1]) begin
      owner_q <= wb_dat_i[POS_OWNER];
    end
  end

  assign owner_is_companion = owner_q;

  // ************************************************************
  // port power
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      power_q <= RST_POWER;
    end else if (!PWR_CAPABLE) begin
      power_q <= 1'b1;
    end else if (power_q && oc_q) begin
      power_q <= 1'b0;
    end else if (wr_stb && hit(wb_adr_i, ADDR_PORT_STATUS) && wb_sel_i[1]) begin
      power_q <= wb_dat_i[POS_POWER];
    end
  end

  assign port_power_on = power_q;

  // settle counter restarts on each power-on; drives the power_settled output, not a status bit
  always_ff @(posedge ref_clk) begin
    if (srst || !power_q) begin
      settle_cnt_q <= 32'h0;
    end else if (settle_cnt_q < 32'(SETTLE_CYCLES)) begin
      settle_cnt_q <= settle_cnt_q + 32'h1;
    end
  end

  assign power_settled = power_q && (settle_cnt_q >= 32'(SETTLE_CYCLES));

  // ************************************************************
  // indicator select
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ind_q <= IND_OFF;
    end else if (IND_CAPABLE && wr_stb && hit(wb_adr_i, ADDR_PORT_STATUS) && wb_sel_i[1]) begin
      ind_q <= wb_dat_i[POS_IND_HI:POS_IND_LO];
    end
  end

  assign indicator_select = ind_q;

  // ************************************************************
  // port word decode used by the checks; register logic decodes on its own
  // ************************************************************
  assign port_wr = wr_stb && hit(wb_adr_i, ADDR_PORT_STATUS) && wb_sel_i[1];
  assign status_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q
    && hit(wb_adr_i, ADDR_PORT_STATUS);
  assign ind_wdata = wb_dat_i[POS_IND_HI:POS_IND_LO];
  assign owner_wdata = wb_dat_i[POS_OWNER];
  assign power_wdata = wb_dat_i[POS_POWER];

  // line levels only mean something on a powered, connected, disabled port;
  // elsewhere they read 0, not undefined, so software never sees stale pins
  assign line_ok = power_q && port_connected && !port_enabled;
  assign line_now = {dp_q, dm_q};

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdat_q <= 32'h0;
    end else begin
      rdat_q <= 32'h0;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
        if (hit(wb_adr_i, ADDR_STRUCT_PARAMS)) begin
          rdat_q[POS_PWR_CAP] <= PWR_CAPABLE;
          rdat_q[POS_IND_CAP] <= IND_CAPABLE;
        end else if (hit(wb_adr_i, ADDR_CONFIG_DONE)) begin
          rdat_q[POS_CFG_FLAG] <= configured_flag_q;
        end else if (hit(wb_adr_i, ADDR_PORT_STATUS)) begin
          rdat_q[POS_POWER] <= power_q;
          rdat_q[POS_OWNER] <= owner_q;
          rdat_q[POS_IND_HI:POS_IND_LO] <= ind_q;
          rdat_q[POS_RESERVED9] <= 1'b0;
          if (power_q) begin
            rdat_q[POS_CONNECT] <= port_connected;
            rdat_q[POS_ENABLE] <= port_enabled;
            if (line_ok) begin
              // D+ high bit, D- low bit
              rdat_q[POS_LINE_HI:POS_LINE_LO] <= line_now;
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_owner_forced;
    @(posedge ref_clk) disable iff (srst)
    !configured_flag_q |=> owner_q;
  endproperty
  a_owner_forced: assert property (p_owner_forced) else $error("owner not held");

  sequence s_cfg_rise;
    !configured_flag_q ##1 configured_flag_q;
  endsequence

  property p_owner_clear;
    @(posedge ref_clk) disable iff (srst)
    s_cfg_rise |=> !owner_q;
  endproperty
  a_owner_clear: assert property (p_owner_clear) else $error("owner not cleared");

  property p_no_switch;
    @(posedge ref_clk) disable iff (srst)
    // sampled srst keeps the release edge, where power still shows reset, out
    (!PWR_CAPABLE && !srst) |=> port_power_on;
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("power not forced on");

  property p_oc_drop;
    @(posedge ref_clk) disable iff (srst)
    (PWR_CAPABLE && power_q && oc_q) |=> !power_q;
  endproperty
  a_oc_drop: assert property (p_oc_drop) else $error("power kept on overcurrent");

  property p_ind_locked;
    @(posedge ref_clk) disable iff (srst)
    !IND_CAPABLE |=> $stable(ind_q);
  endproperty
  a_ind_locked: assert property (p_ind_locked) else $error("indicator changed");

  property p_route;
    @(posedge ref_clk) disable iff (srst)
    route_to_companion == !configured_flag_q;
  endproperty
  a_route: assert property (p_route) else $error("routing wrong");

  property p_unpowered_quiet;
    @(posedge ref_clk) disable iff (srst)
    (!power_q && $past(power_q) == 1'b0 && wb_ack_o && !wb_we_i
      && wb_adr_i == ADDR_PORT_STATUS) |-> (wb_dat_o[POS_LINE_HI:POS_CONNECT] == 12'h0);
  endproperty
  a_unpowered_quiet: assert property (p_unpowered_quiet) else $error("status while off");

  property p_reserved;
    @(posedge ref_clk) disable iff (srst)
    wb_ack_o |-> !wb_dat_o[POS_RESERVED9];
  endproperty
  a_reserved: assert property (p_reserved) else $error("bit 9 set");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (srst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

  // reset values, checked in the cycle after every reset edge
  property p_reset_values;
    @(posedge ref_clk)
    srst |=> (ind_q == IND_OFF && owner_q == RST_OWNER && !wb_ack_o);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_ind_write;
    @(posedge ref_clk) disable iff (srst)
    (IND_CAPABLE && port_wr) |=> (ind_q == $past(ind_wdata));
  endproperty
  a_ind_write: assert property (p_ind_write) else $error("indicator not written");

  property p_power_write;
    @(posedge ref_clk) disable iff (srst)
    (PWR_CAPABLE && port_wr && !(power_q && oc_q)) |=> (power_q == $past(power_wdata));
  endproperty
  a_power_write: assert property (p_power_write) else $error("power not written");

  property p_owner_write;
    @(posedge ref_clk) disable iff (srst)
    (port_wr && configured_flag_q && cfg_prev_q) |=> (owner_q == $past(owner_wdata));
  endproperty
  a_owner_write: assert property (p_owner_write) else $error("owner not written");

  sequence s_line_read;
    status_rd && line_ok;
  endsequence

  property p_line_shown;
    @(posedge ref_clk) disable iff (srst)
    s_line_read |=> (wb_dat_o[POS_LINE_HI:POS_LINE_LO] == $past(line_now));
  endproperty
  a_line_shown: assert property (p_line_shown) else $error("line levels wrong");

  property p_line_hidden;
    @(posedge ref_clk) disable iff (srst)
    (status_rd && !line_ok) |=> (wb_dat_o[POS_LINE_HI:POS_LINE_LO] == 2'h0);
  endproperty
  a_line_hidden: assert property (p_line_hidden) else $error("line levels leaked");

endmodule : hs_port_owner_power_line_status

//--- logic/port_owner_pkg.sv
/*
 * Constants for the port owner, power and line-level block: register map of
 * the Wishbone slave, field positions, reset values and timing figures.
 * Assumes a 100 MHz ref_clk and a 32-bit classic Wishbone master.
 */
// Overview of operation
// - indicator_select writes are ignored when the indicator capability bit is 0.
// - indicator_select resets to 0; 00 off, 01 amber, 10 green, 11 undefined.
// - owner_is_companion resets to 1, cleared when configured_flag rises.
// - owner_is_companion is held at 1 while configured_flag is 0.
// - software sets owner for non high-speed devices; 1 hands the port to companion.
// - without power switches the port is always powered and power reads 1; here port_power_on is 0 in reset and goes to 1 one cycle after srst falls.
// - with power switches the power bit drives the switch, 0 off, 1 on.
// - while port power is 0 the port is nonfunctional and reports no status.
// - overcurrent on a powered switched port may clear the power bit.
// - line_levels shows D+ in the upper bit and D- in the lower bit.
// - line_levels valid only when disabled and connected; undefined without power.
// - configured_flag 0 routes port to companion, 1 routes to this controller.
package port_owner_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_STRUCT_PARAMS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG_DONE = 8'h60;
  localparam logic [7:0] ADDR_PORT_STATUS = 8'h64;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_PWR_CAP = 4;
  localparam int POS_IND_CAP = 16;
  localparam int POS_CFG_FLAG = 0;
  localparam int POS_CONNECT = 0;
  localparam int POS_ENABLE = 2;
  localparam int POS_RESERVED9 = 9;
  localparam int POS_LINE_LO = 10;
  localparam int POS_LINE_HI = 11;
  localparam int POS_POWER = 12;
  localparam int POS_OWNER = 13;
  localparam int POS_IND_LO = 14;
  localparam int POS_IND_HI = 15;

  // ************************************************************
  // reset values and encodings
  // ************************************************************
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_AMBER = 2'h1;
  localparam logic [1:0] IND_GREEN = 2'h2;
  localparam logic RST_OWNER = 1'b1;
  localparam logic RST_POWER = 1'b0;
  localparam logic RST_CFG_FLAG = 1'b0;

  // ************************************************************
  // timing: power settle time software must honour
  // ************************************************************
  localparam int PWR_SETTLE_MS = 20;
  localparam int CLK_MHZ = 100;
  localparam int PWR_SETTLE_CYC = PWR_SETTLE_MS * 1000 * CLK_MHZ;

endpackage : port_owner_pkg

//--- test/usb_far_end.sv
/*
 * Partner model: the downstream usb device on the line pins, plus the
 * overcurrent sense of the port power switch.
 * Assumes the bench holds attached, line_mode and oc_req between edges.
 */
`timescale 1ns/10ps
module usb_far_end (
  input wire logic attached,
  input wire logic [1:0] line_mode,
  input wire logic oc_req,
  output logic dp_line,
  output logic dm_line,
  output logic overcurrent,
  output logic port_connected
);
  // line_mode is {d+, d-}; pull-downs hold both low with nothing attached
  always_comb begin
    dp_line = attached & line_mode[1];
    dm_line = attached & line_mode[0];
    overcurrent = oc_req;
    port_connected = attached;
  end
endmodule : usb_far_end

//--- test/hs_port_owner_power_line_status_bench.sv
/*
 * Self-checking bench: wishbone master, behavioural register model, far end.
 * Assumes ack within 40 cycles and a short power settle count for simulation.
 */
`timescale 1ns/10ps
module hs_port_owner_power_line_status_bench;
  import port_owner_pkg::*;
  logic ref_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, attached = 0, oc_req = 0, en = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000, dat_o, r, rnd_q = 32'h0000003D;
  logic ack, dp, dm, oc, conn, pwr_o, own_o, route_o, settled_o;
  logic [1:0] ind_o, line_mode = 2'h0;
  logic [31:0] dat_o2, r2;
  logic pwr2;
  logic [1:0] ind2;
  int fails = 0, n_compared = 0, ind_m = 0, own_m = 1, pwr_m = 0;

  hs_port_owner_power_line_status #(.IND_CAPABLE(1'b1), .PWR_CAPABLE(1'b1),
    .SETTLE_CYCLES(16)) i_dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .dp_line(dp), .dm_line(dm), .overcurrent(oc),
    .port_connected(conn), .port_enabled(en), .port_power_on(pwr_o),
    .owner_is_companion(own_o), .route_to_companion(route_o),
    .indicator_select(ind_o), .power_settled(settled_o));
  usb_far_end i_far (.attached(attached), .line_mode(line_mode), .oc_req(oc_req),
    .dp_line(dp), .dm_line(dm), .overcurrent(oc), .port_connected(conn));
  // second copy with neither indicators nor power switches, same bus and pins
  hs_port_owner_power_line_status #(.IND_CAPABLE(1'b0), .PWR_CAPABLE(1'b0),
    .SETTLE_CYCLES(16)) i_dut_fixed (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o2), .wb_ack_o(), .dp_line(dp), .dm_line(dm), .overcurrent(oc),
    .port_connected(conn), .port_enabled(en), .port_power_on(pwr2),
    .owner_is_companion(), .route_to_companion(), .indicator_select(ind2),
    .power_settled());

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // xorshift source for random line states, seeded with 61
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xorshift = v ^ (v << 5);
  endfunction : xorshift

  // request held until ack is seen at a rising edge; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 40);
    if (ack !== 1'b1) begin
      fails++;
      stop_test();
    end else begin
      r = dat_o;
      r2 = dat_o2;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : wb

  // model of bits 15:9 plus connect and enable; other fields are not ours
  task automatic chk_port();
    logic [31:0] e;
    logic [31:0] e2;
    e = {16'h0000, ind_m[1:0], own_m[0], pwr_m[0], 12'h000};
    if (pwr_m != 0 && attached && !en) e[11:10] = line_mode;
    if (pwr_m != 0) e[2:0] = {en, 1'b0, attached};
    // fixed copy: indicator stays off, always powered, so status always shows
    e2 = {16'h0000, 2'h0, own_m[0], 1'b1, 12'h000};
    if (attached && !en) e2[11:10] = line_mode;
    e2[2:0] = {en, 1'b0, attached};
    wb(1'b0, ADDR_PORT_STATUS, 32'h00000000);
    chk("port_status", e & 32'h0000FE05, r & 32'h0000FE05);
    chk("fixed_status", e2 & 32'h0000FE05, r2 & 32'h0000FE05);
  endtask : chk_port

  task automatic wport(input logic [31:0] d, input int cfg);
    wb(1'b1, ADDR_PORT_STATUS, d);
    ind_m = d[15:14];
    pwr_m = d[12];
    if (cfg != 0) own_m = d[13];
  endtask : wport

  task automatic wcfg(input int v);
    wb(1'b1, ADDR_CONFIG_DONE, v);
    own_m = (v == 0) ? 1 : 0;
    repeat (2) @(posedge ref_clk);
  endtask : wcfg

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int i;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    chk_port();
    chk("route", 32'h1, {31'h0, route_o});
    wb(1'b0, ADDR_STRUCT_PARAMS, 32'h00000000);
    chk("caps", 32'h00010010, r & 32'h00010010);
    chk("fixed_caps", 32'h0, r2 & 32'h00010010);
    wport(32'h00001000, 0);
    chk_port();
    chk("power_pin", 32'h1, {31'h0, pwr_o});
    // no port change until power has settled
    for (i = 0; i < 40 && settled_o !== 1'b1; i++) @(posedge ref_clk);
    chk("settled", 32'h1, {31'h0, settled_o});
    attached <= 1'b1;
    for (i = 0; i < 8; i++) begin
      line_mode <= i[1:0];
      en <= i[2];
      repeat (6) @(posedge ref_clk);
      chk_port();
    end
    en <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rnd_q = xorshift(rnd_q);
      line_mode <= rnd_q[1:0];
      wport({16'h0000, i[1:0], 1'b0, 1'b1, 2'h0, 1'b1, 9'h000}, 0);
      repeat (6) @(posedge ref_clk);
      chk_port();
      chk("ind_pin", {30'h0, i[1:0]}, {30'h0, ind_o});
      chk("fixed_ind", 32'h0, {30'h0, ind2});
    end
    wport(32'h00000000, 0);
    chk_port();
    wcfg(1);
    chk_port();
    chk("route", 32'h0, {31'h0, route_o});
    wport(32'h00003000, 1);
    chk_port();
    chk("owner_pin", 32'h1, {31'h0, own_o});
    wport(32'h00001000, 1);
    // K-state seen: software releases the port to the companion
    line_mode <= 2'h1;
    repeat (6) @(posedge ref_clk);
    chk_port();
    if (r[11:10] == 2'h1) wport(32'h00003000, 1);
    @(posedge ref_clk);
    chk("k_release", 32'h1, {31'h0, own_o});
    wport(32'h00001000, 1);
    oc_req <= 1'b1;
    for (i = 0; i < 20 && pwr_o !== 1'b0; i++) @(posedge ref_clk);
    pwr_m = 0;
    chk("oc_power", 32'h0, {31'h0, pwr_o});
    chk("fixed_power", 32'h1, {31'h0, pwr2});
    oc_req <= 1'b0;
    chk_port();
    wcfg(0);
    chk_port();
    chk("route", 32'h1, {31'h0, route_o});
    wb(1'b0, 8'h20, 32'h00000000);
    chk("unmapped", 32'h0, r);
    stop_test();
  end
endmodule : hs_port_owner_power_line_status_bench
